// [eag_pkg.sv]
// Package with modes, field positions and widths for the address generator
package eag_pkg;

  // Data and address widths
  localparam int DW = 8;
  localparam int AW = 16;

  // Addressing modes, one-hot
  typedef enum logic [10:0] {
    EAG_ACC = 11'h001,
    EAG_IMM = 11'h002,
    EAG_ABS = 11'h004,
    EAG_ZPG = 11'h008,
    EAG_ZPI = 11'h010,
    EAG_ABI = 11'h020,
    EAG_IMP = 11'h040,
    EAG_REL = 11'h080,
    EAG_IDX = 11'h100,
    EAG_IDY = 11'h200,
    EAG_IND = 11'h400
  } eag_mode_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    EAG_S_IDLE = 5'h01,
    EAG_S_PLO  = 5'h02,
    EAG_S_PHI  = 5'h04,
    EAG_S_DONE = 5'h08,
    EAG_S_WAIT = 5'h10
  } eag_state_t;

  // Constant fields
  localparam logic [7:0]  EAG_ZERO_PAGE = 8'h00;
  localparam logic [15:0] EAG_ADDR_RST  = 16'h0000;
  localparam logic [7:0]  EAG_BYTE_RST  = 8'h00;
  localparam int          EAG_SIGN_BIT  = 7;

endpackage : eag_pkg

// [eag_mem_if.sv]
// Interface carrying adder operands and the sum between the generator and its adder
`timescale 1ns/1ps
interface eag_mem_if;
  logic [7:0]  base_lo;   // Low base byte
  logic [7:0]  base_hi;   // High base byte
  logic [7:0]  index;     // Index added to low byte
  logic        zp_wrap;   // Keep result in page zero
  logic [15:0] sum;       // Result address
  modport gen (output base_lo, base_hi, index, zp_wrap, input sum);
  modport add (input base_lo, base_hi, index, zp_wrap, output sum);
endinterface : eag_mem_if

// [eag_adder.sv]
// Sixteen-bit address adder with optional page-zero wrap
`timescale 1ns/1ps
module eag_adder
  import eag_pkg::*;
(
  eag_mem_if.add m
);
  logic [8:0] lo_sum;  // Low byte with carry

  // Low byte add, carry kept for the high byte
  always_comb begin
    lo_sum = {1'b0, m.base_lo} + {1'b0, m.index};
  end

  // Page-zero modes drop the carry; others carry and wrap mod 65536
  always_comb begin
    if (m.zp_wrap) begin
      m.sum = {EAG_ZERO_PAGE, lo_sum[7:0]};
    end else begin
      m.sum = {m.base_hi + {7'h00, lo_sum[8]}, lo_sum[7:0]};
    end
  end
endmodule : eag_adder

// [eag_top.sv]
// Effective-address generator for an 8-bit CPU core
// Operation
// - Accumulator mode: one byte, no memory operand
// - Immediate: operand is second byte, no fetch
// - Absolute: byte two low, byte three high
// - Zero page: one address byte, high zero
// - Zero page indexed: no carry, stays page zero
// - Absolute indexed: add index to 16-bit base
// - Implied: no address bytes fetched
// - Relative only for conditional branches
// - Signed offset added to next-instruction counter
// - Pre-indexed: byte plus X, pointer in page zero
// - Both pre-indexed pointer bytes in page zero
// - Post-indexed: pointer plus Y, carry into high
// - Indirect: read pointer pair, load counter
`timescale 1ns/1ps
module eag_top
  import eag_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  // Instruction request
  input  wire logic        I_START,
  input  wire eag_mode_t   I_MODE,
  input  wire logic        I_USE_Y,
  input  wire logic [7:0]  I_BYTE2,
  input  wire logic [7:0]  I_BYTE3,
  input  wire logic [7:0]  I_X,
  input  wire logic [7:0]  I_Y,
  input  wire logic [15:0] I_PC_NEXT,
  // Memory read port for pointers
  output logic             O_RD,
  output logic [15:0]      O_RD_ADDR,
  input  wire logic        I_RD_VALID,
  input  wire logic [7:0]  I_RD_DATA,
  // Result
  output logic             O_DONE,
  output logic [15:0]      O_EA,
  output logic             O_EA_VALID,
  output logic             O_USE_ACC,
  output logic             O_USE_IMM,
  output logic [7:0]       O_IMM,
  output logic             O_LOAD_PC,
  output logic             O_BUSY
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  eag_state_t  state_r, state_nxt;   // Sequencer state
  eag_mode_t   mode_r;               // Latched mode
  logic [7:0]  b2_r, b3_r;           // Latched instruction bytes
  logic [7:0]  idx_r;                // Latched index
  logic [15:0] pc_r;                 // Counter at next instruction
  logic [15:0] ptr_r;                // Pointer address
  logic [7:0]  plo_r;                // Low pointer data
  logic [15:0] ea_r;                 // Result address
  logic        ea_valid_r, acc_r, imm_r, ldpc_r, done_r;
  logic [15:0] ea_comb;              // Direct result
  logic        needs_ptr;            // Mode reads a pointer pair
  eag_mem_if   m ();                 // Adder link

  eag_adder u_add (.m(m));

  // Next pointer byte: page-zero pointers wrap within page zero
  function automatic logic [15:0] ptr_next(input logic [15:0] p, input logic zp);
    if (zp) ptr_next = {EAG_ZERO_PAGE, p[7:0] + 8'h01};
    else    ptr_next = p + 16'h0001;
  endfunction : ptr_next

  ////////////////////////////////////////////////////////////////////////
  // Adder operand selection
  always_comb begin
    m.base_lo = b2_r;
    m.base_hi = b3_r;
    m.index   = idx_r;
    m.zp_wrap = 1'b0;
    case (mode_r)
      EAG_ZPI: m.zp_wrap = 1'b1;
      EAG_IDX: m.zp_wrap = 1'b1;
      EAG_IDY: begin
        m.base_lo = plo_r;
        m.base_hi = I_RD_DATA;
        m.index   = idx_r;
      end
      EAG_REL: begin
        // Sign-extend offset onto counter; carry wraps 16 bits
        m.base_lo = pc_r[7:0];
        m.base_hi = pc_r[15:8] + {8{b2_r[EAG_SIGN_BIT]}};
        m.index   = b2_r;
      end
      default: ;
    endcase
  end

  // Result for modes needing no pointer read
  always_comb begin
    case (mode_r)
      EAG_ABS: ea_comb = {b3_r, b2_r};
      EAG_ZPG: ea_comb = {EAG_ZERO_PAGE, b2_r};
      EAG_ZPI, EAG_ABI, EAG_REL: ea_comb = m.sum;
      default: ea_comb = EAG_ADDR_RST;
    endcase
  end

  assign needs_ptr = (mode_r == EAG_IDX) || (mode_r == EAG_IDY) || (mode_r == EAG_IND);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EAG_S_IDLE: if (I_START) state_nxt = EAG_S_WAIT;
      EAG_S_WAIT: state_nxt = needs_ptr ? EAG_S_PLO : EAG_S_DONE;
      EAG_S_PLO:  if (I_RD_VALID) state_nxt = EAG_S_PHI;
      EAG_S_PHI:  if (I_RD_VALID) state_nxt = EAG_S_DONE;
      EAG_S_DONE: state_nxt = EAG_S_IDLE;
      default:    state_nxt = EAG_S_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) state_r <= EAG_S_IDLE;
    else         state_r <= state_nxt;
  end

  // Capture the instruction on start
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      mode_r <= EAG_IMP;
      b2_r   <= EAG_BYTE_RST;
      b3_r   <= EAG_BYTE_RST;
      idx_r  <= EAG_BYTE_RST;
      pc_r   <= EAG_ADDR_RST;
    end else if (state_r == EAG_S_IDLE && I_START) begin
      mode_r <= I_MODE;
      b2_r   <= I_BYTE2;
      b3_r   <= I_BYTE3;
      // X for pre-indexed, Y for post-indexed, else the chosen index
      idx_r  <= (I_MODE == EAG_IDY || (I_USE_Y && I_MODE != EAG_IDX)) ? I_Y : I_X;
      pc_r   <= I_PC_NEXT;
    end
  end

  // Pointer address and low pointer byte
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      ptr_r <= EAG_ADDR_RST;
      plo_r <= EAG_BYTE_RST;
    end else if (state_r == EAG_S_WAIT) begin
      case (mode_r)
        EAG_IDX: ptr_r <= m.sum;
        EAG_IDY: ptr_r <= {EAG_ZERO_PAGE, b2_r};
        default: ptr_r <= {b3_r, b2_r};
      endcase
    end else if (state_r == EAG_S_PLO && I_RD_VALID) begin
      plo_r <= I_RD_DATA;
      ptr_r <= ptr_next(ptr_r, mode_r != EAG_IND);
    end
  end

  // Result registers; pure operand modes give no address
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      ea_r       <= EAG_ADDR_RST;
      ea_valid_r <= 1'b0;
      acc_r      <= 1'b0;
      imm_r      <= 1'b0;
      ldpc_r     <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == EAG_S_WAIT && !needs_ptr) begin
        done_r     <= 1'b1;
        ea_r       <= ea_comb;
        ea_valid_r <= (mode_r == EAG_ABS) || (mode_r == EAG_ZPG) || (mode_r == EAG_ZPI)
                   || (mode_r == EAG_ABI) || (mode_r == EAG_REL);
        acc_r      <= (mode_r == EAG_ACC);
        imm_r      <= (mode_r == EAG_IMM);
        ldpc_r     <= (mode_r == EAG_REL);
      end else if (state_r == EAG_S_PHI && I_RD_VALID) begin
        done_r     <= 1'b1;
        ea_valid_r <= 1'b1;
        acc_r      <= 1'b0;
        imm_r      <= 1'b0;
        ldpc_r     <= (mode_r == EAG_IND);
        if (mode_r == EAG_IDY) ea_r <= m.sum;
        else                   ea_r <= {I_RD_DATA, plo_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; implied mode fetches nothing and flags nothing
  assign O_RD       = (state_r == EAG_S_PLO) || (state_r == EAG_S_PHI);
  assign O_RD_ADDR  = ptr_r;
  assign O_DONE     = done_r;
  assign O_EA       = ea_r;
  assign O_EA_VALID = ea_valid_r;
  assign O_USE_ACC  = acc_r;
  assign O_USE_IMM  = imm_r;
  assign O_IMM      = b2_r;
  assign O_LOAD_PC  = ldpc_r;
  assign O_BUSY     = (state_r != EAG_S_IDLE);

endmodule : eag_top

// [eag_top_properties.sv]
// Port checker for the effective-address generator
`timescale 1ns/1ps
module eag_props
  import eag_pkg::*;
(
  input wire logic        I_CLOCK, I_NRST, I_START, O_RD, I_RD_VALID,
  input wire logic        O_DONE, O_USE_ACC, O_USE_IMM, O_BUSY,
  input wire eag_mode_t   I_MODE,
  input wire logic [7:0]  I_BYTE2, I_BYTE3, O_IMM,
  input wire logic [15:0] O_RD_ADDR, O_EA
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  // Request accepted at this edge; later starts while busy are refused
  wire tk = I_START && !O_BUSY;
  a_acc_flags: assert property (tk && I_MODE==EAG_ACC |-> ##2 O_DONE && O_USE_ACC)
    else $error("accumulator flag missing");
  a_imm_oper: assert property (tk && I_MODE==EAG_IMM |-> ##2 O_IMM==$past(I_BYTE2,2))
    else $error("immediate byte wrong");
  // Both bytes checked, so a swapped high and low byte cannot slip through
  a_abs_addr: assert property (tk && I_MODE==EAG_ABS |-> ##2
    O_EA=={$past(I_BYTE3,2), $past(I_BYTE2,2)})
    else $error("absolute address wrong");
  a_zpg_addr: assert property (tk && I_MODE==EAG_ZPG |-> ##2 O_EA=={8'h00,$past(I_BYTE2,2)})
    else $error("zero page address wrong");
  a_zpi_page: assert property (tk && I_MODE==EAG_ZPI |-> ##2 O_DONE && O_EA[15:8]==8'h00)
    else $error("indexed zero page left page zero");
  a_imp_nofetch: assert property (tk && I_MODE==EAG_IMP |=> (!O_RD)[*3])
    else $error("implied mode read memory");
  // Only five cycles: a following pointer request cannot read that early
  a_idx_page: assert property (tk && I_MODE==EAG_IDX |=>
    (!O_RD || O_RD_ADDR[15:8]==8'h00)[*5])
    else $error("pointer read left page zero");
  a_rd_hold: assert property (O_RD && !I_RD_VALID |=> O_RD && $stable(O_RD_ADDR))
    else $error("read dropped before answer");
  a_ptr_done: assert property (tk && I_MODE==EAG_IND |-> ##[3:12] O_DONE)
    else $error("indirect result late");
endmodule : eag_props

bind eag_top eag_props u_props (.*);

// [eag_mem_model.sv]
// Behavioural pointer memory with random answer delay
`timescale 1ns/1ps
module eag_mem_model (
  input  wire logic        I_CLOCK, I_NRST, O_RD,
  input  wire logic [15:0] O_RD_ADDR,
  output logic             I_RD_VALID,
  output logic [7:0]       I_RD_DATA
);
  int unsigned w;  // Wait cycles left before answering
  ////////////////////////////////////////
  // Answers on the falling edge; stale data is inverted each cycle
  // so a late sample never looks like a good byte
  always @(negedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      I_RD_VALID <= 1'b0;
      I_RD_DATA  <= 8'h00;
      w          <= 0;
    end else if (!O_RD || I_RD_VALID) begin
      I_RD_VALID <= 1'b0;
      I_RD_DATA  <= ~I_RD_DATA;
      w          <= $urandom % 3;
    end else if (w == 0) begin
      I_RD_VALID <= 1'b1;
      I_RD_DATA  <= O_RD_ADDR[7:0] ^ O_RD_ADDR[15:8] ^ 8'h3c;
    end else begin
      w         <= w - 1;
      I_RD_DATA <= ~I_RD_DATA;
    end
  end
endmodule : eag_mem_model

// [tb_cpu_effective_address_gen.sv]
// Self-checking bench for the effective-address generator
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_cpu_effective_address_gen
  import eag_pkg::*;
;
  logic I_CLOCK = 0, I_NRST = 0, I_START = 0, I_USE_Y = 0, I_RD_VALID;
  eag_mode_t I_MODE = EAG_ACC;
  logic [7:0] I_BYTE2 = 0, I_BYTE3 = 0, I_X = 0, I_Y = 0, I_RD_DATA, O_IMM;
  logic [15:0] I_PC_NEXT = 0, O_RD_ADDR, O_EA;
  logic O_RD, O_DONE, O_EA_VALID, O_USE_ACC, O_USE_IMM, O_LOAD_PC, O_BUSY;
  logic [27:0] q[$];  // Expected results, oldest first
  logic [27:0] got_v, exp_v;  // Observed and expected result of one done pulse
  int fails = 0, tests_run = 0;
  eag_top uut (.*);
  eag_mem_model u_mem (.*);
  initial forever #5 I_CLOCK = ~I_CLOCK;
  ////////////////////////////////////////
  // Model of the pointer memory contents
  function automatic logic [7:0] mf(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mf
  // Expected address, flags and immediate byte for one request
  function automatic logic [27:0] calc(eag_mode_t m, logic [7:0] b2, b3, x, y,
                                       logic uy, logic [15:0] pc);
    logic [7:0] ix, p;
    logic [15:0] ea;
    logic v, ld;
    ix = uy ? y : x;
    v = 1;
    ld = 0;
    ea = 0;
    case (m)
      EAG_ABS: ea = {b3, b2};
      EAG_ZPG: ea = {8'h00, b2};
      EAG_ZPI: ea = {8'h00, b2 + ix};
      EAG_ABI: ea = {b3, b2} + ix;
      EAG_REL: begin
        ea = pc + {{8{b2[7]}}, b2};
        ld = 1;
      end
      EAG_IDX: begin
        p = b2 + x;
        ea = {mf({8'h00, p + 8'h01}), mf({8'h00, p})};
      end
      EAG_IDY: ea = {mf({8'h00, b2 + 8'h01}), mf({8'h00, b2})} + y;
      EAG_IND: begin
        ea = {mf({b3, b2} + 16'h0001), mf({b3, b2})};
        ld = 1;
      end
      default: v = 0;  // No memory address in these modes
    endcase
    return {ea, v, m == EAG_ACC, m == EAG_IMM, ld, b2};
  endfunction : calc
  ////////////////////////////////////////
  // One request; start stays up a second cycle with changed bytes,
  // which the busy block must ignore
  task automatic go(eag_mode_t m, bit all_ones);
    int n;
    n = 0;
    while (O_BUSY !== 1'b0 && n < 50) begin
      @(negedge I_CLOCK);
      n++;
    end
    // A block that never goes idle is a failure, not a reason to press on
    if (n >= 50) begin
      fails++;
      print_verdict;
    end
    I_MODE = m;
    I_USE_Y = 1'($urandom);
    {I_BYTE2, I_BYTE3, I_X, I_Y} = all_ones ? 32'hffffffff : $urandom;
    I_PC_NEXT = all_ones ? 16'h0000 : 16'($urandom);
    I_START = 1;
    q.push_back(calc(m, I_BYTE2, I_BYTE3, I_X, I_Y, I_USE_Y, I_PC_NEXT));
    @(negedge I_CLOCK);
    I_BYTE2 = ~I_BYTE2;
    I_X = ~I_X;
    @(negedge I_CLOCK);
    I_START = 0;
  endtask : go
  task print_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////
  // Result watcher: each done pulse takes the oldest expectation
  always @(negedge I_CLOCK) begin
    if (O_DONE === 1'b1) begin
      got_v = {O_EA, O_EA_VALID, O_USE_ACC, O_USE_IMM, O_LOAD_PC, O_IMM};
      exp_v = q.size() ? q.pop_front() : 'x;
      `CHK(got_v, exp_v)
    end
  end
  // Main sequence: every mode, first pass with all-ones wrap corners
  initial begin
    void'($urandom(10));
    repeat (5) @(posedge I_CLOCK);
    // Look at the reset outputs away from the edge, where they are settled
    @(negedge I_CLOCK);
    `CHK({O_DONE, O_RD, O_EA}, 18'h0)
    I_NRST = 1;
    for (int i = 0; i < 99; i++)
      go(eag_mode_t'(11'h001 << (i % 11)), i < 11);
    repeat (50) if (q.size()) @(negedge I_CLOCK);
    `CHK(q.size(), 0)
    print_verdict;
  end
  // Watchdog for a hung handshake
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
endmodule : tb_cpu_effective_address_gen
